// ==== rtl/acc_unit.sv ====
/*
  Accumulator datapath: load from memory, store to memory and add with
  carry, with carry, zero, overflow, negative and decimal flags.
  Assumes a synchronous memory on clk_i that answers a read strobe with
  data in the next cycle, and a bus master that resolves addressing
  modes into a final address before issuing a command.
*/
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module acc_unit
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // register port
  input  wire logic [REG_AW-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // memory bus
  output logic      [MEM_AW-1:0] mem_addr_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  input  wire logic [DATA_W-1:0] mem_data_i,
  output logic      [DATA_W-1:0] mem_data_o,
  output logic                   mem_data_oe_o
);

  typedef struct packed {
    state_e      st;
    logic [7:0]  acc;
    logic [15:0] addr;
    logic [7:0]  imm;
    logic [1:0]  op;
    logic [2:0]  mode;
    logic        fc;
    logic        fz;
    logic        fd;
    logic        fv;
    logic        fn;
    logic        err;
    logic [7:0]  rdata;
  } q_s;

  localparam q_s Q_RST = '{st: ST_IDLE, acc: BYTE_RST, addr: ADDR_RST,
                           imm: BYTE_RST, op: OP_LOAD, mode: MODE_IMM,
                           fc: 1'b0, fz: 1'b0, fd: 1'b0, fv: 1'b0,
                           fn: 1'b0, err: 1'b0, rdata: BYTE_RST};

  q_s         q_r;
  q_s         q_nxt;
  logic       rst_meta_r;
  logic       rst_b_r;
  logic [7:0] operand;
  logic [7:0] sum;
  logic       sum_c;
  logic       sum_v;
  logic [1:0] cmd_op;
  logic [2:0] cmd_mode;

  // register address match, shared by the read and write decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // status byte in its fixed layout
  function automatic logic [7:0] status_byte(input q_s q);
    logic [7:0] s;
    s        = 8'h00;
    s[FLG_C] = q.fc;
    s[FLG_Z] = q.fz;
    s[FLG_D] = q.fd;
    s[FLG_V] = q.fv;
    s[FLG_N] = q.fn;
    return s;
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_b_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b_r    <= rst_meta_r;
    end
  end

  // immediate operand comes from its register, others from the bus
  assign operand  = (q_r.mode == MODE_IMM) ? q_r.imm : mem_data_i;
  assign cmd_op   = reg_wdata_i[CMD_OP_LSB +: OP_W];
  assign cmd_mode = reg_wdata_i[CMD_MD_LSB +: MODE_W];

  acc_adder acc_adder_i (
    .a_i        (q_r.acc),
    .b_i        (operand),
    .carry_i    (q_r.fc),
    .decimal_i  (q_r.fd),
    .sum_o      (sum),
    .carry_o    (sum_c),
    .overflow_o (sum_v)
  );

  // next-state logic: register writes first, sequencer wins after
  always_comb begin
    q_nxt       = q_r;
    q_nxt.rdata = BYTE_RST;

    // carry and decimal are software-owned bits outside the acc
    if (reg_wr_i && hit(reg_addr_i, OFS_STATUS)) begin
      q_nxt.fc = reg_wdata_i[FLG_C];
      q_nxt.fd = reg_wdata_i[FLG_D];
    end
    // address and operand frozen while a command runs
    if (reg_wr_i && q_r.st == ST_IDLE) begin
      if (hit(reg_addr_i, OFS_ADDR_LO)) begin
        q_nxt.addr[7:0] = reg_wdata_i;
      end
      if (hit(reg_addr_i, OFS_ADDR_HI)) begin
        q_nxt.addr[15:8] = reg_wdata_i;
      end
      if (hit(reg_addr_i, OFS_IMM)) begin
        q_nxt.imm = reg_wdata_i;
      end
    end

    case (q_r.st)
      ST_IDLE: begin
        if (reg_wr_i && hit(reg_addr_i, OFS_CMD)) begin
          q_nxt.op   = cmd_op;
          q_nxt.mode = cmd_mode;
          // only load, store and add: no memory-to-memory path
          if (cmd_op != OP_LOAD && cmd_op != OP_STORE &&
              cmd_op != OP_ADC) begin
            q_nxt.err = 1'b1;
          end else if (cmd_op == OP_STORE && cmd_mode == MODE_IMM) begin
            q_nxt.err = 1'b1;
          end else begin
            q_nxt.err = 1'b0;
            // zero-page forms keep the high address byte at zero
            if (cmd_mode == MODE_ZP || cmd_mode == MODE_ZPX) begin
              q_nxt.addr[15:8] = BYTE_RST;
            end
            if (cmd_op == OP_STORE) begin
              q_nxt.st = ST_WRITE;
            end else if (cmd_mode == MODE_IMM) begin
              q_nxt.st = ST_EXEC;
            end else begin
              q_nxt.st = ST_READ;
            end
          end
        end
      end
      ST_READ: begin
        q_nxt.st = ST_EXEC;
      end
      ST_EXEC: begin
        if (q_r.op == OP_LOAD) begin
          q_nxt.acc = operand;
          q_nxt.fz  = (operand == BYTE_RST);
          q_nxt.fn  = operand[SIGN_BIT];
        end else begin
          q_nxt.acc = sum;
          q_nxt.fc  = sum_c;
          q_nxt.fv  = sum_v;
          q_nxt.fz  = (sum == BYTE_RST);
          q_nxt.fn  = sum[SIGN_BIT];
        end
        q_nxt.st = ST_IDLE;
      end
      ST_WRITE: begin
        q_nxt.st = ST_IDLE;
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    // a command written while busy is refused and flagged
    if (reg_wr_i && hit(reg_addr_i, OFS_CMD) && q_r.st != ST_IDLE) begin
      q_nxt.err = 1'b1;
    end

    // read data stand in the cycle after the strobe only
    if (reg_rd_i) begin
      if (hit(reg_addr_i, OFS_ACC)) begin
        q_nxt.rdata = q_r.acc;
      end else if (hit(reg_addr_i, OFS_STATUS)) begin
        q_nxt.rdata = status_byte(q_r);
      end else if (hit(reg_addr_i, OFS_ADDR_LO)) begin
        q_nxt.rdata = q_r.addr[7:0];
      end else if (hit(reg_addr_i, OFS_ADDR_HI)) begin
        q_nxt.rdata = q_r.addr[15:8];
      end else if (hit(reg_addr_i, OFS_IMM)) begin
        q_nxt.rdata = q_r.imm;
      end else if (hit(reg_addr_i, OFS_CMD)) begin
        q_nxt.rdata[CMD_BUSY] = (q_r.st != ST_IDLE);
        q_nxt.rdata[CMD_ERR]  = q_r.err;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_r) begin
    if (!rst_b_r) begin
      q_r <= Q_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from state; bus driven only in the write cycle
  assign reg_rdata_o   = q_r.rdata;
  assign mem_addr_o    = q_r.addr;
  assign mem_rd_o      = (q_r.st == ST_READ);
  assign mem_wr_o      = (q_r.st == ST_WRITE);
  assign mem_data_oe_o = (q_r.st == ST_WRITE);
  assign mem_data_o    = q_r.acc;

  // helper for the decimal carry check, valid digits only
  function automatic int bcd_val(input logic [7:0] b);
    return int'(b[7:4]) * 10 + int'(b[3:0]);
  endfunction

  logic bcd_ok;
  logic dec_over;
  logic bin_over;
  assign bcd_ok   = (q_r.acc[7:4] < 4'hA) && (q_r.acc[3:0] < 4'hA) &&
                    (operand[7:4] < 4'hA) && (operand[3:0] < 4'hA);
  assign dec_over = (bcd_val(q_r.acc) + bcd_val(operand) +
                     int'(q_r.fc)) > DEC_MAX;
  assign bin_over = (int'(q_r.acc) + int'(operand) +
                     int'(q_r.fc)) > BIN_MAX;

  // overflow follows the binary sum, in decimal mode as well
  logic [7:0] bin_low;
  assign bin_low = q_r.acc + operand + {7'h00, q_r.fc};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_r);

  logic exec_load;
  logic exec_adc;
  assign exec_load = (q_r.st == ST_EXEC) && (q_r.op == OP_LOAD);
  assign exec_adc  = (q_r.st == ST_EXEC) && (q_r.op == OP_ADC);

  sequence load_cmd_s;
    reg_wr_i && hit(reg_addr_i, OFS_CMD) && q_r.st == ST_IDLE &&
    cmd_op == OP_LOAD && cmd_mode != MODE_IMM;
  endsequence

  sequence read_exec_s;
    mem_rd_o && !mem_data_oe_o ##1 q_r.st == ST_EXEC ##1 !mem_rd_o;
  endsequence

  mem_load_a: assert property (
    load_cmd_s |=> read_exec_s)
    else $error("memory load did not read then execute");

  load_value_a: assert property (
    exec_load |=> q_r.acc == $past(operand) &&
                  q_r.fz == ($past(operand) == 8'h00) &&
                  q_r.fn == $past(operand[7]))
    else $error("load result or zero/negative flag wrong");

  load_keep_cv_a: assert property (
    exec_load && !(reg_wr_i && hit(reg_addr_i, OFS_STATUS))
    |=> $stable(q_r.fc) && $stable(q_r.fv))
    else $error("load disturbed carry or overflow");

  store_drive_a: assert property (
    mem_wr_o |-> mem_data_oe_o && mem_data_o == q_r.acc && !mem_rd_o
    ##1 !mem_data_oe_o && $stable(q_r.acc) && $stable(q_r.fz) &&
    $stable(q_r.fn) && $stable(q_r.fv))
    else $error("store drove wrong byte or changed state");

  store_no_imm_a: assert property (
    reg_wr_i && hit(reg_addr_i, OFS_CMD) && q_r.st == ST_IDLE &&
    cmd_op == OP_STORE && cmd_mode == MODE_IMM
    |=> (q_r.err && q_r.st == ST_IDLE) [*2])
    else $error("immediate store was not refused");

  adc_sum_a: assert property (
    exec_adc && !q_r.fd |=> q_r.acc == 8'($past(q_r.acc) +
                   $past(operand) + {7'h00, $past(q_r.fc)}))
    else $error("binary add result wrong");

  adc_bin_carry_a: assert property (
    exec_adc && !q_r.fd |=> q_r.fc == $past(bin_over))
    else $error("binary carry wrong");

  adc_dec_carry_a: assert property (
    exec_adc && q_r.fd && bcd_ok |=> q_r.fc == $past(dec_over))
    else $error("decimal carry wrong");

  adc_ovf_a: assert property (
    exec_adc |=> q_r.fv == (($past(q_r.acc[7]) == $past(operand[7])) &&
                  ($past(bin_low[7]) != $past(q_r.acc[7]))))
    else $error("overflow flag wrong");

  adc_nz_a: assert property (
    exec_adc |=> q_r.fn == q_r.acc[7] && q_r.fz == (q_r.acc == 8'h00))
    else $error("negative or zero flag wrong after add");

endmodule // acc_unit

// ==== rtl/acc_pkg.sv ====
/*
  Shared constants for the accumulator load/store/add unit: register
  offsets, field positions, reset values, command and mode codes and
  the sequencer state encoding.
  Assumes an 8-bit register port and a synchronous 8-bit memory bus.
*/
package acc_pkg;

  // register port geometry
  localparam int          REG_AW      = 8;
  localparam int          DATA_W      = 8;
  localparam int          MEM_AW      = 16;

  // register byte offsets
  localparam logic [7:0]  OFS_ACC     = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_ADDR_LO = 8'h08;
  localparam logic [7:0]  OFS_ADDR_HI = 8'h0C;
  localparam logic [7:0]  OFS_IMM     = 8'h10;
  localparam logic [7:0]  OFS_CMD     = 8'h14;

  // status register bit positions
  localparam int          FLG_C       = 0;
  localparam int          FLG_Z       = 1;
  localparam int          FLG_D       = 3;
  localparam int          FLG_V       = 6;
  localparam int          FLG_N       = 7;
  localparam int          SIGN_BIT    = 7;

  // command register fields
  localparam int          CMD_OP_LSB  = 0;
  localparam int          OP_W        = 2;
  localparam int          CMD_MD_LSB  = 2;
  localparam int          MODE_W      = 3;
  localparam int          CMD_BUSY    = 0;
  localparam int          CMD_ERR     = 1;

  // operation codes
  localparam logic [1:0]  OP_LOAD     = 2'h0;
  localparam logic [1:0]  OP_STORE    = 2'h1;
  localparam logic [1:0]  OP_ADC      = 2'h2;

  // addressing modes
  localparam logic [2:0]  MODE_IMM    = 3'h0;
  localparam logic [2:0]  MODE_ABS    = 3'h1;
  localparam logic [2:0]  MODE_ZP     = 3'h2;
  localparam logic [2:0]  MODE_ABSX   = 3'h3;
  localparam logic [2:0]  MODE_ABSY   = 3'h4;
  localparam logic [2:0]  MODE_ZPX    = 3'h5;
  localparam logic [2:0]  MODE_INDX   = 3'h6;
  localparam logic [2:0]  MODE_INDY   = 3'h7;

  // reset values and decimal correction
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [15:0] ADDR_RST    = 16'h0000;
  localparam logic [4:0]  DIGIT_MAX   = 5'h09;
  localparam logic [4:0]  DIGIT_ADJ   = 5'h06;
  localparam int          BIN_MAX     = 255;
  localparam int          DEC_MAX     = 99;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_READ  = 4'h2,
    ST_EXEC  = 4'h4,
    ST_WRITE = 4'h8
  } state_e;

endpackage

// ==== rtl/acc_adder.sv ====
/*
  Eight-bit adder with carry in, carry out and signed overflow, with an
  optional packed BCD correction per nibble.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module acc_adder
  import acc_pkg::*;
(
  // operands
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       carry_i,
  input  wire logic       decimal_i,
  // results
  output logic      [7:0] sum_o,
  output logic            carry_o,
  output logic            overflow_o
);

  logic [8:0] bin;
  logic [4:0] lo;
  logic [4:0] hi;
  logic       lo_c;
  logic       hi_c;

  // binary sum and nibble-wise decimal correction
  always_comb begin
    bin  = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
    lo   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_i};
    lo_c = lo > DIGIT_MAX;
    if (lo_c) begin
      lo = lo + DIGIT_ADJ;
    end
    hi   = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo_c};
    hi_c = hi > DIGIT_MAX;
    if (hi_c) begin
      hi = hi + DIGIT_ADJ;
    end
    if (decimal_i) begin
      sum_o   = {hi[3:0], lo[3:0]};
      carry_o = hi_c;
    end else begin
      sum_o   = bin[7:0];
      carry_o = bin[8];
    end
    // sign corrupted when like-signed operands give an unlike sign
    overflow_o = (a_i[SIGN_BIT] == b_i[SIGN_BIT]) &&
                 (bin[SIGN_BIT] != a_i[SIGN_BIT]);
  end

endmodule // acc_adder

// ==== tb/mem_bus_model.sv ====
/*
  Behavioural memory on the far side of the accumulator unit's data bus.
  Assumes one clock shared with the unit; the bench may preload or peek
  the byte array directly between commands.
*/
`timescale 1ns/1ps
module mem_bus_model (
  // clock
  input  wire logic        clk_i,
  // bus from the unit
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic        oe_i,
  input  wire logic [7:0]  wdata_i,
  // read data back to the unit
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:65535];

  initial rdata_o = 8'h5A;

  // answer one cycle after the strobe, then let the byte go stale
  always @(posedge clk_i) begin
    if (rd_i) begin
      rdata_o <= mem[addr_i];
    end else begin
      rdata_o <= ~rdata_o; // released lines must not look valid
    end
    // a write only lands while the unit really drives the lines
    if (wr_i && oe_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule // mem_bus_model

// ==== tb/accumulator_load_store_add_unit_tb.sv ====
/*
  Self-checking bench for the accumulator unit: register port tasks,
  load, store and add sequences with expected values worked out here.
  Assumes acc_pkg and the memory model compiled before this file.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module accumulator_load_store_add_unit_tb;
  import acc_pkg::*;
  logic        clk_i       = 1'b0;
  logic        rst_b_i     = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  reg_rdata_o, mem_data_i, mem_data_o, r;
  logic [15:0] mem_addr_o, ea;
  logic        mem_rd_o, mem_wr_o, mem_data_oe_o;
  logic [15:0] ex;
  int          fails        = 0;
  int          total_checks = 0;
  // adder cases: accumulator, operand, carry in, decimal
  logic [7:0]  ta [9] = '{8'h0D, 8'h7F, 8'h05, 8'h80, 8'hFF, 8'h58,
                          8'h50, 8'h50, 8'h7F};
  logic [7:0]  tm [9] = '{8'hD3, 8'h02, 8'hFD, 8'h80, 8'h00, 8'h46,
                          8'h49, 8'h50, 8'h02};
  logic [8:0]  tc     = 9'b000110001;
  logic [8:0]  td     = 9'b011100000;
  logic [7:0]  tl [8] = '{8'h00, 8'h80, 8'h7F, 8'h01, 8'hFF, 8'h40,
                          8'hA5, 8'h00};

  always #12.5 clk_i = ~clk_i;

  acc_unit acc_unit_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_data_i(mem_data_i),
    .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));

  mem_bus_model mem_bus_model_i (
    .clk_i(clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .oe_i(mem_data_oe_o), .wdata_i(mem_data_o), .rdata_o(mem_data_i));

  // one-cycle strobes, held until the sampling edge has passed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic chk_rd(input logic [7:0] a, m, e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d & m, e)
  endtask
  // issue a command and poll busy under a bounded count
  task automatic op(input logic [1:0] o, input logic [2:0] m);
    int n;
    wr(OFS_CMD, {3'h0, m, o});
    for (n = 0; n < 10; n++) begin
      rd(OFS_CMD, r);
      if (r[CMD_BUSY] === 1'b0) break;
    end
    if (n == 10) fails++;
  endtask
  // zero page modes drop the high address byte
  function automatic logic [15:0] eff(input logic [2:0] m);
    return (m == MODE_ZP || m == MODE_ZPX) ? 16'h0034 : 16'h1234;
  endfunction
  task automatic put(input logic [2:0] m, input logic [7:0] v);
    if (m == MODE_IMM) begin
      wr(OFS_IMM, v);
    end else begin
      // zero-page commands clear the high byte, so put it back each time
      wr(OFS_ADDR_HI, 8'h12);
      mem_bus_model_i.mem[eff(m)] = v;
    end
  endtask
  // expected {status, acc}; status bits 5,4,2 masked off when read
  function automatic logic [15:0] adc_x(input logic [7:0] a, m,
                                        input logic c, d);
    logic [8:0] s;
    logic [4:0] lo, hi;
    logic [7:0] q;
    logic       co;
    s = a + m + c;
    q = s[7:0];
    co = s[8];
    if (d) begin
      lo = a[3:0] + m[3:0] + c;
      if (lo > 9) lo = lo + 5'h06;
      hi = a[7:4] + m[7:4] + lo[4];
      if (hi > 9) hi = hi + 5'h06;
      q = {hi[3:0], lo[3:0]};
      co = hi[4];
    end
    return {q[7], (a[7] == m[7]) && (s[7] != a[7]), 2'h0, d, 1'b0,
            q == 8'h00, co, q};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // reset values, read-only and unmapped places
    wr(OFS_ACC, 8'hAA);
    wr(8'h20, 8'h55);
    chk_rd(OFS_ACC, 8'hFF, 8'h00);
    chk_rd(OFS_STATUS, 8'hCB, 8'h00);
    chk_rd(8'h20, 8'hFF, 8'h00);
    wr(OFS_ADDR_HI, 8'h12);
    wr(OFS_ADDR_LO, 8'h34);
    chk_rd(OFS_ADDR_HI, 8'hFF, 8'h12);
    chk_rd(OFS_ADDR_LO, 8'hFF, 8'h34);
    // only carry and decimal take a status write; decimal is cleared again, carry kept
    wr(OFS_STATUS, 8'hFF);
    chk_rd(OFS_STATUS, 8'hCB, 8'h09);
    wr(OFS_STATUS, 8'h01);
    chk_rd(OFS_STATUS, 8'hCB, 8'h01);
    $display("test registers done");
    // loads in every mode keep carry, set zero and sign from the byte
    for (int m = 0; m < 8; m++) begin
      put(m[2:0], tl[m]);
      op(OP_LOAD, m[2:0]);
      chk_rd(OFS_ACC, 8'hFF, tl[m]);
      chk_rd(OFS_STATUS, 8'hCB,
             {tl[m][7], 5'h00, tl[m] == 8'h00, 1'b1});
    end
    $display("test load done");
    // stores in seven modes leave acc and flags alone
    put(MODE_IMM, 8'hC3);
    op(OP_LOAD, MODE_IMM);
    for (int m = 1; m < 8; m++) begin
      ea = eff(m[2:0]);
      put(m[2:0], 8'h3C);
      op(OP_STORE, m[2:0]);
      `CHK(mem_bus_model_i.mem[ea], 8'hC3)
      chk_rd(OFS_ACC, 8'hFF, 8'hC3);
      chk_rd(OFS_STATUS, 8'hCB, 8'h81);
    end
    // no immediate store: refused with the error bit
    op(OP_STORE, MODE_IMM);
    `CHK(r[CMD_ERR], 1'b1)
    $display("test store done");
    // add with carry over all modes, binary and decimal
    for (int i = 0; i < 9; i++) begin
      ex = adc_x(ta[i], tm[i], tc[i], td[i]);
      put(MODE_IMM, ta[i]);
      op(OP_LOAD, MODE_IMM);
      wr(OFS_STATUS, {4'h0, td[i], 2'h0, tc[i]});
      put(3'(i % 8), tm[i]);
      op(OP_ADC, 3'(i % 8));
      chk_rd(OFS_ACC, 8'hFF, ex[7:0]);
      chk_rd(OFS_STATUS, 8'hCB, ex[15:8]);
    end
    // overflow survives a load that sets zero
    put(MODE_IMM, 8'h00);
    op(OP_LOAD, MODE_IMM);
    chk_rd(OFS_STATUS, 8'hCB, 8'h42);
    $display("test add done");
    // a command while busy is refused, the next good one clears error
    mem_bus_model_i.mem[16'h1234] = 8'h3C;
    wr(OFS_IMM, 8'h01);
    wr(OFS_CMD, {3'h0, MODE_ABS, OP_LOAD});
    op(OP_ADC, MODE_IMM);
    `CHK(r[CMD_ERR], 1'b1)
    chk_rd(OFS_ACC, 8'hFF, 8'h3C);
    op(OP_LOAD, MODE_IMM);
    `CHK(r[CMD_ERR], 1'b0)
    op(2'h3, MODE_IMM);
    `CHK(r & 8'h03, 8'h02)
    chk_rd(OFS_ACC, 8'hFF, 8'h01);
    $display("test refusal done");
    test_done();
  end
endmodule // accumulator_load_store_add_unit_tb
